// File: hw/mitp_target.sv
// Target end of the monitor serial port, link logic on the link clock
`timescale 1ns/10ps
module mitp_target #(
  parameter bit VARIANT_B = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        linkClk,
  input  wire logic        linkRst,
  input  wire logic [1:0]  addressStrapPin,
  input  wire logic        alertPending,
  input  wire logic [15:0] rdData,
  output logic      [7:0]  rdPtr,
  output logic             wrStrobe,
  output logic      [7:0]  wrPtr,
  output logic      [15:0] wrData,
  output logic             softReset,
  output logic             convStart,
  output logic             alertAnswered,
  mitp_link_if.target      link
);
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_SKIP} mitp_st_e;
  mitp_st_e state;
  mitp_st_e nxt;
  logic sclM, sclS, sclD, sdaM, sdaS, sdaD;
  logic sclF, sdaF, sclFD, sdaFD;
  logic strapM0, strapM1;
  logic [1:0] strapS;
  logic alertM, alertS;
  logic hsMode;
  logic [6:0] ownAddr;
  logic [7:0] shift;
  logic [3:0] bitCnt;
  logic [2:0] byteIdx;
  logic isGc, isAra, txLow, ctrlAck, answered;
  logic [7:0] ptr, hiByte;
  logic [15:0] word, rdHold, rdSnap;
  localparam int N_EVT_L = mitp_pkg::N_EVT;
  logic [N_EVT_L-1:0] evTog, evPulse;
  logic rdReqM, rdReqS, rdAck, rdAckM, rdAckS, rdTog;
  logic startC, stopC, rise, fall;
  logic doAck, toTx, alertHeld;
  localparam logic [4:0] BASE = VARIANT_B ? mitp_pkg::BASE_B
                                          : mitp_pkg::BASE_A;
  // ----------------------------------------------------------------
  // Pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      {sclM, sclS, sclD, sdaM, sdaS, sdaD} <= 6'h3F;
      {strapM0, strapM1, strapS} <= 4'h0;
      {alertM, alertS} <= 2'h0;
    end else begin
      sclM    <= link.scl;
      sclS    <= sclM;
      sclD    <= sclS;
      sdaM    <= link.sda;
      sdaS    <= sdaM;
      sdaD    <= sdaS;
      strapM0 <= addressStrapPin[0];
      strapM1 <= addressStrapPin[1];
      strapS  <= {strapM1, strapM0};
      alertM  <= alertPending;
      alertS  <= alertM;
    end
  end
  // Fast mode wants two agreeing samples; high speed cannot afford it
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      {sclF, sdaF, sclFD, sdaFD} <= 4'hF;
    end else begin
      sclF  <= (hsMode || sclS == sclD) ? sclS : sclF;
      sdaF  <= (hsMode || sdaS == sdaD) ? sdaS : sdaF;
      sclFD <= sclF;
      sdaFD <= sdaF;
    end
  end
  assign startC = sclF && sclFD && sdaFD && !sdaF;
  assign stopC  = sclF && sclFD && !sdaFD && sdaF;
  assign rise   = sclF && !sclFD;
  assign fall   = !sclF && sclFD;
  assign alertHeld = alertS && !answered;
  // ----------------------------------------------------------------
  // Byte decision
  // ----------------------------------------------------------------
  always_comb begin
    doAck = 1'b0;
    toTx  = 1'b0;
    case (byteIdx)
      3'h0: begin
        if (shift[7:1] == ownAddr) begin
          doAck = 1'b1;
          toTx  = shift[0];
        end else if (shift[7:1] == mitp_pkg::GC_ADDR) begin
          doAck = 1'b1;
        end else if (shift[7:1] == mitp_pkg::ARA_ADDR && shift[0]
                     && alertHeld) begin
          doAck = 1'b1;
          toTx  = 1'b1;
        end
      end
      3'h1: doAck = isGc ? (shift == mitp_pkg::GC_RESET_CODE) : 1'b1;
      3'h2, 3'h3: doAck = !isGc;
      default: doAck = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Protocol engine; reacts to controller edges, and clears answered while alertS is low
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      state   <= ST_IDLE;
      nxt     <= ST_IDLE;
      hsMode  <= 1'b0;
      ownAddr <= {BASE, 2'h0};
      shift   <= 8'h00;
      bitCnt  <= 4'h0;
      byteIdx <= 3'h0;
      {isGc, isAra, txLow, ctrlAck, answered} <= 5'h00;
      ptr     <= mitp_pkg::PTR_RESET;
      hiByte  <= 8'h00;
      word    <= mitp_pkg::WORD_RESET;
      evTog   <= '0;
    end else begin
      if (!alertS) answered <= 1'b0;
      if (stopC) begin
        state  <= ST_IDLE;
        hsMode <= 1'b0;
      end else if (startC) begin
        state   <= ST_RX;
        bitCnt  <= 4'h0;
        byteIdx <= 3'h0;
        ownAddr <= {BASE, strapS};
      end else begin
        case (state)
          ST_RX: begin
            if (rise) begin
              shift  <= {shift[6:0], sdaF};
              bitCnt <= bitCnt + 4'h1;
            end else if (fall && bitCnt == mitp_pkg::BYTE_BITS) begin
              bitCnt  <= 4'h0;
              state   <= doAck ? ST_ACK : ST_SKIP;
              byteIdx <= byteIdx + 3'h1;
              nxt     <= toTx ? ST_TX : ST_RX;
              if (byteIdx == 3'h0) begin
                isGc  <= shift[7:1] == mitp_pkg::GC_ADDR;
                isAra <= shift[7:1] == mitp_pkg::ARA_ADDR;
                txLow <= 1'b0;
                if (shift[7:3] == mitp_pkg::HS_CODE_TOP)
                  hsMode <= 1'b1;
                if (shift[7:1] == mitp_pkg::GC_ADDR && shift[0]) begin
                  evTog[mitp_pkg::EV_CONV] <=
                    ~evTog[mitp_pkg::EV_CONV];
                  nxt <= ST_SKIP;
                end
                if (toTx)
                  shift <= (shift[7:1] == mitp_pkg::ARA_ADDR)
                           ? {ownAddr, 1'b0} : rdHold[15:8];
              end else if (byteIdx == 3'h1 && isGc) begin
                if (doAck) begin
                  evTog[mitp_pkg::EV_SRST] <=
                    ~evTog[mitp_pkg::EV_SRST];
                  ptr <= mitp_pkg::PTR_RESET;
                end
              end else if (byteIdx == 3'h1) begin
                ptr <= shift;
                evTog[mitp_pkg::EV_PTR] <= ~evTog[mitp_pkg::EV_PTR];
              end else if (byteIdx == 3'h2) begin
                hiByte <= shift;
              end else if (byteIdx == 3'h3 && !isGc) begin
                word <= {hiByte, shift};
                evTog[mitp_pkg::EV_WORD] <= ~evTog[mitp_pkg::EV_WORD];
              end
            end
          end
          ST_ACK: begin
            if (fall) begin
              state  <= nxt;
              bitCnt <= 4'h0;
            end
          end
          ST_TX: begin
            if (rise) begin
              bitCnt <= bitCnt + 4'h1;
              if (isAra && shift[7] && !sdaF)
                state <= ST_SKIP;
            end else if (fall) begin
              if (bitCnt == mitp_pkg::BYTE_BITS) begin
                state <= ST_TXACK;
                if (isAra) begin
                  answered <= 1'b1;
                  evTog[mitp_pkg::EV_ALERT] <=
                    ~evTog[mitp_pkg::EV_ALERT];
                end
              end else begin
                shift <= {shift[6:0], 1'b1};
              end
            end
          end
          ST_TXACK: begin
            if (rise) begin
              ctrlAck <= !sdaF;
            end else if (fall) begin
              if (ctrlAck && !txLow && !isAra) begin
                shift  <= rdHold[7:0];
                txLow  <= 1'b1;
                bitCnt <= 4'h0;
                state  <= ST_TX;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_SKIP, ST_IDLE: state <= state;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Line drivers; clock line is never driven, so no stretching
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      link.devSdaOut   <= 1'b0;
      link.devSdaOeN   <= 1'b1;
      link.devAlertOut <= 1'b0;
      link.devAlertOeN <= 1'b1;
    end else begin
      link.devSdaOut   <= 1'b0;
      link.devSdaOeN   <= !(state == ST_ACK ||
                            (state == ST_TX && !shift[7]));
      link.devAlertOut <= 1'b0;
      link.devAlertOeN <= !alertHeld;
    end
  end
  // ----------------------------------------------------------------
  // Read word crossing: free-running toggle handshake
  // ----------------------------------------------------------------
  // Snapshot refreshes every few cycles; no stretch is needed to wait
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      {rdReqM, rdReqS, rdAck} <= 3'h0;
      rdHold <= mitp_pkg::WORD_RESET;
    end else begin
      rdReqM <= rdTog;
      rdReqS <= rdReqM;
      if (rdReqS != rdAck) begin
        rdHold <= rdSnap;
        rdAck  <= rdReqS;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      {rdAckM, rdAckS, rdTog} <= 3'h0;
      rdSnap <= mitp_pkg::WORD_RESET;
    end else begin
      rdAckM <= rdAck;
      rdAckS <= rdAckM;
      if (rdAckS == rdTog) begin
        rdSnap <= rdData;
        rdTog  <= ~rdTog;
      end
    end
  end
  // ----------------------------------------------------------------
  // Event crossings into the system domain
  // ----------------------------------------------------------------
  for (genvar e = 0; e < N_EVT_L; e++) begin : g_evt
    mitp_evt_sync u_sync (
      .clk   (mclk),
      .rst   (rst),
      .tog   (evTog[e]),
      .pulse (evPulse[e])
    );
  end
  // Pointer and word are stable for many cycles after their toggle
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdPtr         <= mitp_pkg::PTR_RESET;
      wrStrobe      <= 1'b0;
      wrPtr         <= mitp_pkg::PTR_RESET;
      wrData        <= mitp_pkg::WORD_RESET;
      softReset     <= 1'b0;
      convStart     <= 1'b0;
      alertAnswered <= 1'b0;
    end else begin
      wrStrobe      <= evPulse[mitp_pkg::EV_WORD];
      softReset     <= evPulse[mitp_pkg::EV_SRST];
      convStart     <= evPulse[mitp_pkg::EV_CONV];
      alertAnswered <= evPulse[mitp_pkg::EV_ALERT];
      if (evPulse[mitp_pkg::EV_SRST])
        rdPtr <= mitp_pkg::PTR_RESET;
      else if (evPulse[mitp_pkg::EV_PTR])
        rdPtr <= ptr;
      if (evPulse[mitp_pkg::EV_WORD]) begin
        wrPtr  <= ptr;
        wrData <= word;
      end
    end
  end
endmodule

// File: include/mitp_pkg.sv
// Shared constants and types of the monitor serial target port
package mitp_pkg;
  // ----------------------------------------------------------------
  // Rates and clock division
  // ----------------------------------------------------------------
  localparam int MCLK_KHZ = 40000;
  localparam int FS_KHZ   = 400;
  localparam int HS_KHZ   = 2940;
  // Quarter-bit counts round up so the bus never runs above the limit
  localparam int QTR_FS   = (MCLK_KHZ + 4 * FS_KHZ - 1) / (4 * FS_KHZ);
  localparam int QTR_HS   = (MCLK_KHZ + 4 * HS_KHZ - 1) / (4 * HS_KHZ);
  // ----------------------------------------------------------------
  // Addresses and codes
  // ----------------------------------------------------------------
  localparam logic [6:0] GC_ADDR       = 7'h00;
  localparam logic [6:0] ARA_ADDR      = 7'h0C;
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;
  localparam logic [7:0] HS_CODE       = 8'h08;
  localparam logic [7:0] GC_RESET_CODE = 8'h06;
  localparam logic [4:0] BASE_A        = 5'h10;
  localparam logic [4:0] BASE_B        = 5'h12;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  // ----------------------------------------------------------------
  // Event crossings from link domain to system domain
  // ----------------------------------------------------------------
  localparam int N_EVT     = 5;
  localparam int EV_PTR    = 0;
  localparam int EV_WORD   = 1;
  localparam int EV_SRST   = 2;
  localparam int EV_CONV   = 3;
  localparam int EV_ALERT  = 4;
  typedef enum logic [2:0] {
    OP_WRITE, OP_SETPTR, OP_READ, OP_GCRST, OP_GCCONV, OP_ARA
  } mitp_op_e;
endpackage

// File: include/mitp_link_if.sv
// Two-wire bus plus alert line joining controller and target
`timescale 1ns/10ps
interface mitp_link_if;
  logic hostSclOut;
  logic hostSclOeN;
  logic hostSdaOut;
  logic hostSdaOeN;
  logic devSdaOut;
  logic devSdaOeN;
  logic devAlertOut;
  logic devAlertOeN;
  logic scl;
  logic sda;
  logic alertN;
  // Open-drain wires: released lines float high through the pull-ups
  assign scl    = hostSclOeN ? 1'b1 : hostSclOut;
  assign sda    = (hostSdaOeN ? 1'b1 : hostSdaOut) &
                  (devSdaOeN ? 1'b1 : devSdaOut);
  assign alertN = devAlertOeN ? 1'b1 : devAlertOut;
  modport target (input scl, input sda,
                  output devSdaOut, output devSdaOeN,
                  output devAlertOut, output devAlertOeN);
  modport host (input scl, input sda, input alertN,
                output hostSclOut, output hostSclOeN,
                output hostSdaOut, output hostSdaOeN);
endinterface

// File: hw/mitp_evt_sync.sv
// Toggle-to-pulse crossing of one event into the system clock
`timescale 1ns/10ps
module mitp_evt_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tog,
  output logic      pulse
);
  logic meta;
  logic stable;
  logic stableD;
  // ----------------------------------------------------------------
  // Two flops, then edge detect on the second only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta    <= 1'b0;
      stable  <= 1'b0;
      stableD <= 1'b0;
      pulse   <= 1'b0;
    end else begin
      meta    <= tog;
      stable  <= meta;
      stableD <= stable;
      pulse   <= stable ^ stableD;
    end
  end
endmodule

// File: hw/mitp_controller.sv
// Controller end: drives the bus clock and frames each command
`timescale 1ns/10ps
module mitp_controller #(
  parameter int QTR_FS_P = mitp_pkg::QTR_FS,
  parameter int QTR_HS_P = mitp_pkg::QTR_HS
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             cmdValid,
  input  wire mitp_pkg::mitp_op_e cmdOp,
  input  wire logic [6:0]       cmdTarget,
  input  wire logic [7:0]       cmdPtr,
  input  wire logic [15:0]      cmdData,
  input  wire logic             cmdHs,
  output logic                  cmdReady,
  output logic                  rspValid,
  output logic      [15:0]      rspData,
  output logic                  rspNack,
  mitp_link_if.host             link
);
  typedef enum {H_IDLE, H_START, H_TX, H_RX, H_STOP} mitp_hst_e;
  mitp_hst_e st;
  logic sdaM, sdaS;
  logic [7:0] qCnt;
  logic [1:0] phase;
  logic [3:0] bitCnt;
  logic [2:0] byteIdx, nTx;
  logic [1:0] rxLeft;
  logic [7:0] seq [4];
  logic [7:0] shift;
  logic hsPend, hsAct, nackSeen;
  logic tick;
  assign tick = (st != H_IDLE) && (qCnt == 8'h00);
  // ----------------------------------------------------------------
  // Bit-rate divider; the bus clock is made here
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || st == H_IDLE)
      qCnt <= 8'h00;
    else if (qCnt == 8'h00)
      qCnt <= hsAct ? 8'(QTR_HS_P - 1) : 8'(QTR_FS_P - 1);
    else
      qCnt <= qCnt - 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdaM <= 1'b1;
      sdaS <= 1'b1;
    end else begin
      sdaM <= link.sda;
      sdaS <= sdaM;
    end
  end
  // ----------------------------------------------------------------
  // Framing engine, four quarters per bit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st       <= H_IDLE;
      cmdReady <= 1'b1;
      rspValid <= 1'b0;
      rspData  <= mitp_pkg::WORD_RESET;
      rspNack  <= 1'b0;
      phase    <= 2'h0;
      bitCnt   <= 4'h0;
      byteIdx  <= 3'h0;
      nTx      <= 3'h0;
      rxLeft   <= 2'h0;
      shift    <= 8'h00;
      {hsPend, hsAct, nackSeen} <= 3'h0;
      for (int i = 0; i < 4; i++) seq[i] <= 8'h00;
      link.hostSclOut <= 1'b0;
      link.hostSclOeN <= 1'b1;
      link.hostSdaOut <= 1'b0;
      link.hostSdaOeN <= 1'b1;
    end else begin
      rspValid <= 1'b0;
      if (st == H_IDLE && cmdValid && cmdReady) begin
        cmdReady <= 1'b0;
        rspNack  <= 1'b0;
        hsPend   <= cmdHs;
        st       <= H_START;
        phase    <= 2'h0;
        byteIdx  <= 3'h0;
        rxLeft   <= 2'h0;
        seq[0]   <= {cmdTarget, 1'b0};
        seq[1]   <= cmdPtr;
        seq[2]   <= cmdData[15:8];
        seq[3]   <= cmdData[7:0];
        nTx      <= 3'h1;
        case (cmdOp)
          mitp_pkg::OP_WRITE:  nTx <= 3'h4;
          mitp_pkg::OP_SETPTR: nTx <= 3'h2;
          mitp_pkg::OP_READ: begin
            seq[0] <= {cmdTarget, 1'b1};
            rxLeft <= 2'h2;
          end
          mitp_pkg::OP_GCRST: begin
            seq[0] <= {mitp_pkg::GC_ADDR, 1'b0};
            seq[1] <= mitp_pkg::GC_RESET_CODE;
            nTx    <= 3'h2;
          end
          mitp_pkg::OP_GCCONV: seq[0] <= {mitp_pkg::GC_ADDR, 1'b1};
          mitp_pkg::OP_ARA: begin
            seq[0] <= {mitp_pkg::ARA_ADDR, 1'b1};
            rxLeft <= 2'h1;
          end
          default: nTx <= 3'h1;
        endcase
      end else if (tick) begin
        phase <= phase + 2'h1;
        case (st)
          H_START: begin
            case (phase)
              2'h0: link.hostSdaOeN <= 1'b1;
              2'h1: link.hostSclOeN <= 1'b1;
              2'h2: link.hostSdaOeN <= 1'b0;
              default: begin
                link.hostSclOeN <= 1'b0;
                st     <= H_TX;
                bitCnt <= 4'h0;
                shift  <= hsPend ? mitp_pkg::HS_CODE : seq[byteIdx[1:0]];
              end
            endcase
          end
          H_TX: begin
            case (phase)
              2'h0: link.hostSdaOeN <=
                      (bitCnt == mitp_pkg::BYTE_BITS) || shift[7];
              2'h1: link.hostSclOeN <= 1'b1;
              2'h2: nackSeen <= sdaS;
              default: begin
                link.hostSclOeN <= 1'b0;
                if (bitCnt != mitp_pkg::BYTE_BITS) begin
                  shift  <= {shift[6:0], 1'b1};
                  bitCnt <= bitCnt + 4'h1;
                end else if (hsPend) begin
                  hsPend <= 1'b0;
                  hsAct  <= 1'b1;
                  st     <= H_START;
                end else if (nackSeen) begin
                  rspNack <= 1'b1;
                  st      <= H_STOP;
                end else if (byteIdx + 3'h1 < nTx) begin
                  byteIdx <= byteIdx + 3'h1;
                  shift   <= seq[2'(byteIdx + 3'h1)];
                  bitCnt  <= 4'h0;
                end else begin
                  bitCnt <= 4'h0;
                  st     <= (rxLeft != 2'h0) ? H_RX : H_STOP;
                end
              end
            endcase
          end
          H_RX: begin
            case (phase)
              2'h0: link.hostSdaOeN <= (bitCnt != mitp_pkg::BYTE_BITS)
                                       || (rxLeft == 2'h1);
              2'h1: link.hostSclOeN <= 1'b1;
              2'h2: if (bitCnt != mitp_pkg::BYTE_BITS)
                      shift <= {shift[6:0], sdaS};
              default: begin
                link.hostSclOeN <= 1'b0;
                if (bitCnt != mitp_pkg::BYTE_BITS) begin
                  bitCnt <= bitCnt + 4'h1;
                end else begin
                  rspData <= {rspData[7:0], shift};
                  rxLeft  <= rxLeft - 2'h1;
                  bitCnt  <= 4'h0;
                  if (rxLeft == 2'h1) st <= H_STOP;
                end
              end
            endcase
          end
          H_STOP: begin
            case (phase)
              2'h0: link.hostSdaOeN <= 1'b0;
              2'h1: link.hostSclOeN <= 1'b1;
              2'h2: link.hostSdaOeN <= 1'b1;
              default: begin
                st       <= H_IDLE;
                hsAct    <= 1'b0;
                rspValid <= 1'b1;
                cmdReady <= 1'b1;
              end
            endcase
          end
          default: st <= H_IDLE;
        endcase
      end
    end
  end
endmodule

// File: verif/mitp_link_properties.sv
// Wire-level checks on the link between controller and target
`timescale 1ns/10ps
module mitp_link_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hostSdaOeN,
  input wire logic devSdaOut,
  input wire logic devSdaOeN,
  input wire logic devAlertOut,
  input wire logic devAlertOeN,
  input wire logic scl,
  input wire logic sda
);
  logic [7:0] hi;
  logic [7:0] per;
  logic       sclQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // -----------------------------------------------------------------
  // Clock shape counters, saturating so idle spans never wrap short
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    sclQ <= scl;
    hi   <= (rst || !scl) ? 8'h00 : hi + 8'(hi != 8'hFF);
    per  <= rst ? 8'hFF : (scl && !sclQ) ? 8'h01 : per + 8'(per != 8'hFF);
  end
  property p_sda_low; !devSdaOeN |-> !devSdaOut; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("sda driven high");
  property p_alert_low; !devAlertOeN |-> !devAlertOut; endproperty
  a_alert_low: assert property (p_alert_low)
    else $error("alert high");
  property p_start;
    $fell(sda) && scl && $past(scl) |-> !hostSdaOeN && devSdaOeN;
  endproperty
  a_start: assert property (p_start)
    else $error("start not by host");
  property p_stop;
    $rose(sda) && scl && $past(scl) |-> $past(devSdaOeN);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop by target");
  property p_rate; $rose(scl) |-> per >= 8'h0D; endproperty
  a_rate: assert property (p_rate)
    else $error("clock too fast");
  property p_high; $fell(scl) |-> hi >= 8'h06; endproperty
  a_high: assert property (p_high)
    else $error("clock high too short");
  // Long high phases only: the data window is then settled
  property p_hold; scl && hi > 8'h0A |-> $stable(devSdaOeN); endproperty
  a_hold: assert property (p_hold)
    else $error("sda moved, scl high");
  property p_quiet;
    $fell(sda) && scl && hi > 8'h0A |=> devSdaOeN [*8];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("target drove early");
endmodule

// File: verif/tb.sv
// Self-checking bench joining controller and target over the link
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [1:0]         strap;
    mitp_pkg::mitp_op_e op;
    logic [6:0]         tgt;
    logic [7:0]         ptr;
    logic [15:0]        data;
    logic               hs;
    logic [15:0]        exp;
    logic               nack;
    logic [2:0]         puls;
  } mitp_row_s;
  logic mclk = 1'b0, linkClk = 1'b0, rst = 1'b1, cmdValid = 1'b0;
  logic cmdHs = 1'b0, alertPending = 1'b0;
  logic [1:0]  strap = 2'h0;
  logic [6:0]  cmdTarget = 7'h00;
  logic [7:0]  cmdPtr = 8'h00;
  logic [15:0] cmdData = 16'h0000;
  mitp_pkg::mitp_op_e cmdOp = mitp_pkg::OP_WRITE;
  logic        cmdReady, rspValid, rspNack, wrStrobe, softReset;
  logic        convStart, alertAnswered;
  logic [15:0] rspData, rdData, wrData;
  logic [7:0]  rdPtr, wrPtr;
  logic [15:0] regs [256] = '{default: 16'h0000};
  logic [3:0]  seen = 4'h0;
  int          n_mismatch = 0;
  int          n_compared = 0;
  mitp_row_s rows [9] = '{
    '{2'h0, mitp_pkg::OP_WRITE, 7'h40, 8'h03, 16'h1234, 1'b0, 16'h0, 1'b0, 3'h4},
    '{2'h0, mitp_pkg::OP_READ, 7'h40, 8'h00, 16'h0, 1'b0, 16'h1234, 1'b0, 3'h0},
    '{2'h1, mitp_pkg::OP_WRITE, 7'h41, 8'h05, 16'hABCD, 1'b0, 16'h0, 1'b0, 3'h4},
    '{2'h1, mitp_pkg::OP_SETPTR, 7'h41, 8'h03, 16'h0, 1'b0, 16'h0, 1'b0, 3'h0},
    '{2'h1, mitp_pkg::OP_READ, 7'h41, 8'h00, 16'h0, 1'b0, 16'h1234, 1'b0, 3'h0},
    '{2'h2, mitp_pkg::OP_READ, 7'h41, 8'h00, 16'h0, 1'b0, 16'h0, 1'b1, 3'h0},
    '{2'h3, mitp_pkg::OP_WRITE, 7'h4B, 8'h07, 16'h5555, 1'b0, 16'h0, 1'b1, 3'h0},
    '{2'h3, mitp_pkg::OP_GCCONV, 7'h00, 8'h00, 16'h0, 1'b0, 16'h0, 1'b0, 3'h1},
    '{2'h3, mitp_pkg::OP_GCRST, 7'h00, 8'h00, 16'h0, 1'b0, 16'h0, 1'b0, 3'h2}};
  mitp_link_if mitp_link_if_i ();
  // Link side samples at 8 MHz and reacts up to five of its cycles
  // after an edge, so high speed runs with a 400 ns quarter here
  mitp_controller #(.QTR_HS_P(16)) mitp_controller_i (.mclk(mclk),
    .rst(rst),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdTarget(cmdTarget),
    .cmdPtr(cmdPtr), .cmdData(cmdData), .cmdHs(cmdHs), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack),
    .link(mitp_link_if_i));
  mitp_target #(.VARIANT_B(1'b0)) mitp_target_i (.mclk(mclk), .rst(rst),
    .linkClk(linkClk), .linkRst(rst), .addressStrapPin(strap),
    .alertPending(alertPending), .rdData(rdData), .rdPtr(rdPtr),
    .wrStrobe(wrStrobe), .wrPtr(wrPtr), .wrData(wrData),
    .softReset(softReset), .convStart(convStart),
    .alertAnswered(alertAnswered), .link(mitp_link_if_i));
  mitp_link_properties mitp_link_properties_i (.mclk(mclk), .rst(rst),
    .hostSdaOeN(mitp_link_if_i.hostSdaOeN),
    .devSdaOut(mitp_link_if_i.devSdaOut),
    .devSdaOeN(mitp_link_if_i.devSdaOeN),
    .devAlertOut(mitp_link_if_i.devAlertOut),
    .devAlertOeN(mitp_link_if_i.devAlertOeN),
    .scl(mitp_link_if_i.scl), .sda(mitp_link_if_i.sda));
  // -----------------------------------------------------------------
  // Clocks, register file stand-in and pulse catcher
  // -----------------------------------------------------------------
  initial forever #12.5 mclk = ~mclk;
  initial begin
    #7;
    forever #62.5 linkClk = ~linkClk;
  end
  assign rdData = regs[rdPtr];
  always @(posedge mclk) begin
    if (wrStrobe) regs[wrPtr] <= wrData;
    if (softReset) regs <= '{default: 16'h0000};
    seen <= seen | {wrStrobe, softReset, convStart, alertAnswered};
  end
  task automatic check(input string what, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Strap moves with the command so each start sees the new code
  task automatic do_row(input mitp_row_s r);
    int w;
    w = 0;
    @(negedge mclk);
    strap = r.strap;
    cmdOp = r.op;
    cmdTarget = r.tgt;
    cmdPtr = r.ptr;
    cmdData = r.data;
    cmdHs = r.hs;
    seen = 4'h0;
    cmdValid = 1'b1;
    @(negedge mclk);
    cmdValid = 1'b0;
    while (rspValid !== 1'b1 && w < 20000) begin
      @(posedge mclk);
      #1;
      w++;
    end
    repeat (120) @(negedge mclk);
    check("done", 16'(w < 20000), 16'h0001);
    check("nack", 16'(rspNack), 16'(r.nack));
    if (r.op == mitp_pkg::OP_READ && !r.nack) check("word", rspData, r.exp);
    check("pulses", 16'(seen[3:1]), 16'(r.puls));
    $display("done %s", r.op.name());
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    check("ptr", 16'(rdPtr), 16'h0000);
    check("oe", 16'(mitp_link_if_i.devSdaOeN), 16'h0001);
    $display("reset done");
    foreach (rows[i]) do_row(rows[i]);
    check("gcptr", 16'(rdPtr), 16'(mitp_pkg::PTR_RESET));
    alertPending = 1'b1;
    repeat (100) @(negedge mclk);
    check("alert", 16'(mitp_link_if_i.alertN), 16'h0000);
    do_row('{2'h3, mitp_pkg::OP_ARA, 7'h0C, 8'h00, 16'h0, 1'b0, 16'h0,
             1'b0, 3'h0});
    check("ara", {8'h00, rspData[7:0]}, 16'h0086);
    check("won", 16'(seen[0]), 16'h0001);
    check("free", 16'(mitp_link_if_i.alertN), 16'h0001);
    alertPending = 1'b0;
    do_row('{2'h3, mitp_pkg::OP_WRITE, 7'h43, 8'h09, 16'h5AA5, 1'b1,
             16'h0, 1'b0, 3'h4});
    do_row('{2'h3, mitp_pkg::OP_READ, 7'h43, 8'h00, 16'h0, 1'b0,
             16'h5AA5, 1'b0, 3'h0});
    rst = 1'b1;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    check("rstptr", 16'(rdPtr), 16'(mitp_pkg::PTR_RESET));
    $display("mid-run reset done");
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
